// File: src/serial_port_regs.svh
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ==========================================================
// register addresses on the special function register bus
`define SP_DATA_ADDR 8'hf7
`define SP_CTRL_ADDR 8'hf8

// ==========================================================
// reset values
`define SP_DATA_RESET 8'h00
`define SP_CTRL_RESET 8'h00

// ==========================================================
// control/status field positions
`define SP_BIT_DONE 7
`define SP_BIT_WRITE_COLLISION_FLAG 6
`define SP_BIT_ENABLE 5
`define SP_BIT_MASTER 4
`define SP_BIT_IDLE_LEVEL 3
`define SP_BIT_LAUNCH_EDGE 2
`define SP_BIT_RATE_HI 1
`define SP_BIT_RATE_LO 0

// ==========================================================
// timing counts
`define SP_LAST_BIT 4'h7
`define SP_BITS_PER_BYTE 4'h8
`define SP_LAST_EDGE 4'hf
`define SP_HALF_BASE 4'h1

`endif

// File: src/sp_pkg.sv
// ==========================================================
// shared types
package sp_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] rate_t;
   typedef logic [2:0] bit_sel_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_RUN = 4'b0100,
      ST_FINISH = 4'b1000
   } engine_state_e;
endpackage : sp_pkg

// File: src/rate_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

// ==========================================================
// half-period tick: every 2^rate core clocks, so a full
// serial clock period is 2^(rate+1) core clocks
module rate_divider (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   input wire sp_pkg::rate_t rate,
   output logic tick
);
   import sp_pkg::*;

   logic [3:0] count_reg;
   logic [3:0] half_cycles;

   assign half_cycles = `SP_HALF_BASE << rate;
   assign tick = run && (count_reg == half_cycles - `SP_HALF_BASE);

   always_ff @(posedge core_clk) begin
      if (reset || !run || tick) begin
         count_reg <= 4'h0;
      end else begin
         count_reg <= count_reg + `SP_HALF_BASE;
      end
   end
endmodule : rate_divider

`default_nettype wire

// File: src/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-entry buffer between shift engine and data register
module two_entry_buffer (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire sp_pkg::byte_t in_data,
   output logic in_ready,
   output logic out_valid,
   output sp_pkg::byte_t out_data,
   input wire logic out_ready
);
   import sp_pkg::*;

   byte_t mem [0:1];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule : two_entry_buffer

`default_nettype wire

// File: src/spi_master_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

module spi_master_slave_port (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire sp_pkg::byte_t sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire sp_pkg::bit_sel_t sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic sfr_rd,
   output sp_pkg::byte_t sfr_rdata,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic slave_select_n,
   output logic two_wire_select
);
   import sp_pkg::*;

   // ==========================================================
   // state
   byte_t ctrl_reg;
   byte_t ctrl_next;
   byte_t rx_reg;
   logic rx_hold_reg;
   byte_t shift_reg;
   logic out_bit_reg;
   engine_state_e state_reg;
   engine_state_e state_next;
   logic [3:0] edge_cnt_reg;
   logic [3:0] bit_cnt_reg;
   logic sclk_prev_reg;
   logic ss_prev_reg;

   // ==========================================================
   // decode
   logic data_wr;
   logic data_rd;
   logic ctrl_byte_wr;
   logic ctrl_bit_wr;
   byte_t wr_mask;
   byte_t wr_val;
   logic enable;
   logic master;
   logic idle_level;
   logic launch_edge;
   rate_t rate;
   logic busy;
   logic collide;
   logic accept_wr;
   logic tick;
   logic m_edge;
   logic s_edge;
   logic edge_seen;
   logic leading;
   logic sample;
   logic launch;
   logic in_bit;
   logic ss_rise;
   logic m_end;
   logic s_end;
   logic s_abort;
   logic push;
   logic buf_in_ready;
   logic buf_out_valid;
   byte_t buf_out_data;
   logic load_rx;
   logic done_clear_wr;

   assign data_wr = sfr_wr && (sfr_addr == `SP_DATA_ADDR);
   assign data_rd = sfr_rd && (sfr_addr == `SP_DATA_ADDR);
   assign ctrl_byte_wr = sfr_wr && (sfr_addr == `SP_CTRL_ADDR);
   assign ctrl_bit_wr = sfr_bit_wr && (sfr_addr == `SP_CTRL_ADDR);

   always_comb begin
      wr_mask = 8'h00;
      wr_val = 8'h00;
      if (ctrl_byte_wr) begin
         wr_mask = 8'hff;
         wr_val = sfr_wdata;
      end else if (ctrl_bit_wr) begin
         wr_mask = 8'h01 << sfr_bit_sel;
         wr_val = {8{sfr_bit_val}};
      end
   end

   assign enable = ctrl_reg[`SP_BIT_ENABLE];
   assign master = ctrl_reg[`SP_BIT_MASTER];
   assign idle_level = ctrl_reg[`SP_BIT_IDLE_LEVEL];
   assign launch_edge = ctrl_reg[`SP_BIT_LAUNCH_EDGE];
   assign rate = ctrl_reg[`SP_BIT_RATE_HI:`SP_BIT_RATE_LO];

   // slave is busy only once a bit has moved; select low alone is not busy
   assign busy = master ? (state_reg != ST_IDLE)
                        : ((bit_cnt_reg != 4'h0) || (state_reg == ST_FINISH));
   assign collide = data_wr && busy;
   assign accept_wr = data_wr && !busy;
   assign done_clear_wr = wr_mask[`SP_BIT_DONE] && !wr_val[`SP_BIT_DONE];

   // ==========================================================
   // edge classification, shared by master and slave
   assign m_edge = master && (state_reg == ST_RUN) && tick;
   assign s_edge = !master && (state_reg == ST_RUN) && !slave_select_n
                   && (serial_clock_pin_in != sclk_prev_reg);
   assign edge_seen = m_edge || s_edge;
   assign leading = master ? !edge_cnt_reg[0] : (sclk_prev_reg == idle_level);
   assign sample = edge_seen && (leading != launch_edge);
   assign launch = edge_seen && (leading == launch_edge);
   assign in_bit = master ? miso_in : mosi_in;
   assign ss_rise = slave_select_n && !ss_prev_reg;
   assign m_end = m_edge && (edge_cnt_reg == `SP_LAST_EDGE);
   assign s_end = !master && (state_reg == ST_RUN)
                  && (launch_edge ? (sample && bit_cnt_reg == `SP_LAST_BIT)
                                  : (ss_rise && bit_cnt_reg == `SP_BITS_PER_BYTE));
   assign s_abort = !master && (state_reg == ST_RUN) && slave_select_n && !s_end;
   assign push = (state_reg == ST_FINISH);
   assign load_rx = buf_out_valid && !rx_hold_reg;

   rate_divider u_rate_divider (
      .core_clk(core_clk),
      .reset(reset),
      .run(master && (state_reg == ST_RUN)),
      .rate(rate),
      .tick(tick)
   );

   // a full buffer holds the engine in finish, and a master cannot start
   two_entry_buffer u_rx_buffer (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(push),
      .in_data(shift_reg),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(!rx_hold_reg)
   );

   // ==========================================================
   // engine state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (enable && master && accept_wr) begin
               state_next = buf_in_ready ? ST_RUN : ST_WAIT;
            end else if (enable && !master && !slave_select_n) begin
               state_next = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (!enable || !master) begin
               state_next = ST_IDLE;
            end else if (buf_in_ready) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!enable) begin
               state_next = ST_IDLE;
            end else if (m_end || s_end) begin
               state_next = ST_FINISH;
            end else if (s_abort) begin
               state_next = ST_IDLE;
            end
         end
         ST_FINISH: begin
            if (buf_in_ready) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // shift register and outgoing bit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         shift_reg <= `SP_DATA_RESET;
         out_bit_reg <= 1'b0;
      end else if (accept_wr) begin
         shift_reg <= sfr_wdata;
         out_bit_reg <= sfr_wdata[7];
      end else begin
         if (sample) begin
            shift_reg <= {shift_reg[6:0], in_bit};
         end
         if (launch) begin
            out_bit_reg <= shift_reg[7];
         end
      end
   end

   // ==========================================================
   // bit and edge counters
   always_ff @(posedge core_clk) begin
      if (reset || state_reg != ST_RUN || s_end || slave_select_n && !master) begin
         bit_cnt_reg <= 4'h0;
      end else if (sample) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || state_reg != ST_RUN) begin
         edge_cnt_reg <= 4'h0;
      end else if (m_edge) begin
         edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sclk_prev_reg <= 1'b0;
         ss_prev_reg <= 1'b1;
      end else begin
         sclk_prev_reg <= serial_clock_pin_in;
         ss_prev_reg <= slave_select_n;
      end
   end

   // ==========================================================
   // master clock output
   always_ff @(posedge core_clk) begin
      if (reset) begin
         serial_clock_pin_out <= 1'b0;
      end else if (state_reg != ST_RUN) begin
         serial_clock_pin_out <= idle_level;
      end else if (m_edge) begin
         serial_clock_pin_out <= ~serial_clock_pin_out;
      end
   end

   // ==========================================================
   // pin directions and shared-pin select
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
         two_wire_select <= 1'b1;
      end else begin
         mosi_oe <= enable && master;
         serial_clock_pin_oe <= enable && master;
         miso_oe <= enable && !master && !slave_select_n;
         two_wire_select <= !enable;
      end
   end

   assign mosi_out = out_bit_reg;
   assign miso_out = out_bit_reg;

   // ==========================================================
   // received byte register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_reg <= `SP_DATA_RESET;
         rx_hold_reg <= 1'b0;
      end else if (load_rx) begin
         rx_reg <= buf_out_data;
         rx_hold_reg <= 1'b1;
      end else if (data_rd || done_clear_wr) begin
         rx_hold_reg <= 1'b0;
      end
   end

   // ==========================================================
   // control/status register; hardware sets win over clears
   always_comb begin
      ctrl_next = (ctrl_reg & ~wr_mask) | (wr_val & wr_mask);
      if (data_rd) begin
         ctrl_next[`SP_BIT_DONE] = 1'b0;
      end
      if (load_rx) begin
         ctrl_next[`SP_BIT_DONE] = 1'b1;
      end
      if (collide) begin
         ctrl_next[`SP_BIT_WRITE_COLLISION_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_reg <= `SP_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ==========================================================
   // read data, one cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd && sfr_addr == `SP_DATA_ADDR) begin
         sfr_rdata <= rx_reg;
      end else if (sfr_rd && sfr_addr == `SP_CTRL_ADDR) begin
         sfr_rdata <= {ctrl_reg[7:1], master ? ctrl_reg[0] : slave_select_n};
      end else begin
         sfr_rdata <= 8'h00;
      end
   end
endmodule : spi_master_slave_port

`default_nettype wire

// File: bench/port_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

// ==========================================================
// port checker
module port_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire sp_pkg::byte_t sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire sp_pkg::bit_sel_t sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic sfr_rd,
   input wire sp_pkg::byte_t sfr_rdata,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic serial_clock_pin_out,
   input wire logic serial_clock_pin_oe,
   input wire logic slave_select_n,
   input wire logic two_wire_select
);
   import sp_pkg::*;
   byte_t ctl_reg;
   logic clk_q;
   logic pol_q;
   logic [5:0] still_reg;
   // shadow of control writes; the design's own copy is not visible here
   always_ff @(posedge core_clk) begin
      if (reset) ctl_reg <= 8'h00;
      else if (sfr_wr && sfr_addr == `SP_CTRL_ADDR) ctl_reg <= sfr_wdata;
      else if (sfr_bit_wr && sfr_addr == `SP_CTRL_ADDR) ctl_reg[sfr_bit_sel] <= sfr_bit_val;
   end
   always_ff @(posedge core_clk) begin
      clk_q <= serial_clock_pin_out;
      pol_q <= ctl_reg[3];
   end
   // longer than any half period, so a quiet clock must be idle
   always_ff @(posedge core_clk) begin
      if (reset || !mosi_oe || clk_q != serial_clock_pin_out || pol_q != ctl_reg[3]) begin
         still_reg <= 6'h00;
      end else if (still_reg != 6'h28) begin
         still_reg <= still_reg + 6'h01;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence data_read_s;
      sfr_rd && sfr_addr == `SP_DATA_ADDR;
   endsequence
   sequence ctrl_read_s;
      sfr_rd && sfr_addr == `SP_CTRL_ADDR;
   endsequence
   pins_master_a: assert property (
      $rose(ctl_reg[5] && ctl_reg[4]) |-> ##[0:2] mosi_oe && serial_clock_pin_oe)
      else $error("master pins not driven");
   two_wire_a: assert property ($rose(ctl_reg[5]) |-> ##[0:2] !two_wire_select)
      else $error("pins not handed to serial port");
   no_clash_a: assert property (!(mosi_oe && miso_oe))
      else $error("both data lines driven");
   miso_select_a: assert property (
      miso_oe |-> !(slave_select_n && $past(slave_select_n) && $past(slave_select_n, 2)))
      else $error("slave output while deselected");
   idle_clk_a: assert property (still_reg == 6'h0c |-> serial_clock_pin_out == ctl_reg[3])
      else $error("serial clock not at idle level");
   rdata_zero_a: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
      else $error("read data outside read slot");
   unmapped_a: assert property (
      sfr_rd && sfr_addr != `SP_DATA_ADDR && sfr_addr != `SP_CTRL_ADDR |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   done_read_a: assert property (data_read_s ##[1:2] ctrl_read_s |=> !sfr_rdata[7])
      else $error("done flag survives data read");
   slave_bit0_a: assert property (
      ctrl_read_s and !ctl_reg[4] && slave_select_n == $past(slave_select_n, 2)
      |=> sfr_rdata[0] == $past(slave_select_n))
      else $error("select level not in bit 0");
endmodule : port_props

bind spi_master_slave_port port_props chk (.core_clk(core_clk), .reset(reset),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
   .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
   .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
   .slave_select_n(slave_select_n), .two_wire_select(two_wire_select));
`default_nettype wire

// File: bench/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// external slave on the far side of a master transfer
module spi_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic pol,
   input wire logic ph,
   input wire logic load,
   input wire sp_pkg::byte_t tx,
   output logic miso,
   output sp_pkg::byte_t rx
);
   import sp_pkg::*;
   byte_t sh;
   initial miso = 1'b0;
   assign rx = sh;
   // phase 1 has no bit before the first edge: park the inverse
   always @(posedge load) begin
      sh = tx;
      miso = ph ? ~tx[7] : tx[7];
   end
   // same polarity and phase as the device
   always @(sclk) begin
      if ((sclk != pol) == ph) begin
         miso = sh[7];
      end else begin
         sh = {sh[6:0], mosi};
      end
   end
endmodule : spi_slave_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.svh"

module testbench;
   import sp_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_val = 1'b0;
   logic mosi_in = 1'b0, sclk_in = 1'b0, ssel_n = 1'b1, pol = 1'b0, ph = 1'b0, load = 1'b0;
   logic mosi_out, mosi_oe, miso_out, miso_oe, miso_in, sclk_out, sclk_oe, two_wire_select;
   logic [7:0] sfr_addr = 8'h00;
   byte_t sfr_wdata = 8'h00, ptx = 8'h00, sfr_rdata, prx;
   bit_sel_t sfr_bit_sel = 3'h0;
   int err_total = 0, tests_run = 0, nedge = 0;
   time t0 = 0, t1 = 0;
   logic sclk_q = 1'b0;

   always #2.5 core_clk = ~core_clk;

   spi_master_slave_port uut (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
      .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
      .serial_clock_pin_in(sclk_in), .serial_clock_pin_out(sclk_out),
      .serial_clock_pin_oe(sclk_oe), .slave_select_n(ssel_n),
      .two_wire_select(two_wire_select));
   spi_slave_model partner (.sclk(sclk_out), .mosi(mosi_out), .pol(pol), .ph(ph),
      .load(load), .tx(ptx), .miso(miso_in), .rx(prx));

   // ==========================================================
   // serial clock edge monitor
   always @(negedge core_clk) begin
      if (sclk_out !== sclk_q) begin
         if (nedge == 0) t0 = $time;
         nedge++;
         t1 = $time;
      end
      sclk_q = sclk_out;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   // k: 0 read, 1 byte write, 2 bit write with d[3] value and d[2:0] bit
   task automatic acc(input logic [7:0] a, input logic [1:0] k, input byte_t d,
                      output byte_t q);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_bit_sel = d[2:0];
      sfr_bit_val = d[3];
      sfr_rd = (k == 2'd0);
      sfr_wr = (k == 2'd1);
      sfr_bit_wr = (k == 2'd2);
      @(negedge core_clk);
      sfr_rd = 1'b0;
      sfr_wr = 1'b0;
      sfr_bit_wr = 1'b0;
      q = sfr_rdata;
   endtask : acc

   task automatic wait_done(input byte_t want);
      byte_t q;
      q = 8'h00;
      for (int i = 0; i < 200 && q[7] !== 1'b1; i++) acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      chk(q & 8'hc0, want);
   endtask : wait_done

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // ==========================================================
   // scenarios
   task automatic t_reset;
      byte_t q;
      chk({7'h00, two_wire_select}, 8'h01);
      acc(`SP_DATA_ADDR, 2'd0, 8'h00, q);
      chk(q, 8'h00);
      acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      // reset leaves slave mode, so bit 0 shows the deselected pin
      chk(q, 8'h01);
      acc(8'h10, 2'd0, 8'h00, q);
      chk(q, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   // mode m sets polarity, phase and rate together
   task automatic t_master(input logic [1:0] m);
      byte_t q;
      byte_t tx;
      tx = 8'hc3 + {6'h00, m};
      acc(`SP_CTRL_ADDR, 2'd1, {4'h3, m, m}, q);
      pol = m[1];
      ph = m[0];
      ptx = 8'h5a ^ {m, m, m, m};
      // settle byte and phase before the load edge the partner reacts to
      @(negedge core_clk);
      load = 1'b1;
      repeat (2) @(negedge core_clk);
      load = 1'b0;
      nedge = 0;
      chk({5'h00, two_wire_select, mosi_oe, sclk_oe}, 8'h03);
      chk({7'h00, sclk_out}, {7'h00, m[1]});
      acc(`SP_DATA_ADDR, 2'd1, tx, q);
      // second write lands mid-transfer and must be dropped
      acc(`SP_DATA_ADDR, 2'd1, 8'hff, q);
      wait_done(8'hc0);
      chk(8'(nedge), 8'h10);
      chk(8'((t1 - t0) / 5), 8'(15 << m));
      chk({7'h00, sclk_out}, {7'h00, m[1]});
      if (m[0]) begin
         acc(`SP_CTRL_ADDR, 2'd2, 8'h07, q);
         acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
         chk(q & 8'hc0, 8'h40);
      end
      acc(`SP_DATA_ADDR, 2'd0, 8'h00, q);
      chk(q, ptx);
      chk(prx, tx);
      acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      chk(q & 8'hc0, 8'h40);
      acc(`SP_CTRL_ADDR, 2'd2, 8'h06, q);
      acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      chk(q, {4'h3, m, m});
      $display("t_master %0d done", m);
   endtask : t_master

   // p picks the phase: phase 0 frames the byte with select, phase 1 holds it low
   task automatic t_slave(input logic p);
      byte_t q;
      byte_t got;
      byte_t v;
      byte_t want;
      want = p ? 8'h69 : 8'h3c;
      acc(`SP_CTRL_ADDR, 2'd1, {5'h04, p, 2'b00}, q);
      acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      chk(q, {5'h04, p, 2'b01});
      chk({5'h00, miso_oe, mosi_oe, sclk_oe}, 8'h00);
      ssel_n = 1'b0;
      acc(`SP_DATA_ADDR, 2'd1, 8'h96, q);
      acc(`SP_CTRL_ADDR, 2'd0, 8'h00, q);
      chk(q, {5'h04, p, 2'b00});
      got = 8'h00;
      v = want;
      for (int i = 0; i < 8; i++) begin
         sclk_in = 1'b1;
         mosi_in = v[7];
         v = v << 1;
         repeat (4) @(negedge core_clk);
         got = {got[6:0], miso_out};
         sclk_in = 1'b0;
         repeat (4) @(negedge core_clk);
      end
      chk({6'h00, miso_oe, mosi_oe}, 8'h02);
      if (!p) begin
         ssel_n = 1'b1;
      end
      wait_done(8'h80);
      acc(`SP_DATA_ADDR, 2'd0, 8'h00, q);
      chk(q, want);
      chk(got, 8'h96);
      ssel_n = 1'b1;
      $display("t_slave %0d done", p);
   endtask : t_slave

   initial begin
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      t_reset;
      for (int m = 0; m < 4; m++) t_master(2'(m));
      t_slave(1'b1);
      t_slave(1'b0);
      finish_test;
   end

   initial begin
      #100000;
      err_total++;
      finish_test;
   end
endmodule : testbench
`default_nettype wire
